/* File: clbi_cpu_end.sv */
// Processor end: runs local bus cycles for a simple request port
`timescale 1ns/10ps
`include "clbi_consts.svh"
module clbi_cpu_end #(
   parameter int ADDR_W = `CLBI_ADDR_W
) (
   input  wire logic              core_clk,
   input  wire logic              reset,
   clbi_if.cpu                    bus,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [3:0]        req_be_n,
   input  wire clbi_pkg::clbi_cycle_t req_type,
   input  wire logic [31:0]       req_wdata,
   output logic                   rsp_valid,
   output logic [31:0]            rsp_rdata
);
   clbi_pkg::clbi_state_t state;
   logic [ADDR_W-1:0]     addr_q;
   logic [3:0]            be_q;
   logic [3:0]            rem_be;
   logic [2:0]            type_q;
   logic [31:0]           wdata_q;
   logic                  ads_q;
   logic                  pipe_q;
   logic                  phase_q;
   logic [31:0]           dup_data;
   logic                  is_write;
   logic                  ack;
   logic                  need_second;
   logic                  bad_type;
   logic [3:0]            bus_be;

   // ---------------------------------------------------------------
   // Clock phase
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset)
         phase_q <= 1'b0;
      else
         phase_q <= ~phase_q;
   end

   // ---------------------------------------------------------------
   // Request decode
   // ---------------------------------------------------------------
   // The never-occurring code is refused rather than put on the bus
   assign bad_type = (req_type == clbi_pkg::CLBI_NEVER);
   assign is_write = type_q[0];
   // Ready counts in the wait state only, never in the first
   assign ack = (state == clbi_pkg::CLBI_ST_WAIT) && !bus.ready_n;
   // 16-bit bus: a cycle with both halves enabled needs another pass
   assign need_second = !bus.half_width_bus_n && (be_q[1:0] != 2'b11)
                        && (be_q[3:2] != 2'b11);
   // A request is taken only when no half is still pending
   assign req_ready = !reset && !bus.hold && !bad_type &&
                      ((state == clbi_pkg::CLBI_ST_IDLE) ||
                       (ack && !need_second && !pipe_q));

   // ---------------------------------------------------------------
   // Bus state machine
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state  <= clbi_pkg::CLBI_ST_IDLE;
         ads_q  <= 1'b0;
         pipe_q <= 1'b0;
         addr_q <= '0;
         be_q   <= `CLBI_BE_IDLE;
         rem_be <= `CLBI_BE_IDLE;
         type_q <= 3'h0;
         wdata_q <= '0;
      end else begin
         ads_q <= 1'b0;
         unique case (state)
            clbi_pkg::CLBI_ST_IDLE: begin
               if (bus.hold) begin
                  state <= clbi_pkg::CLBI_ST_HELD;
               end else if (req_valid && req_ready) begin
                  addr_q  <= req_addr;
                  be_q    <= req_be_n;
                  type_q  <= req_type;
                  wdata_q <= req_wdata;
                  ads_q   <= 1'b1;
                  state   <= clbi_pkg::CLBI_ST_FIRST;
               end
            end
            clbi_pkg::CLBI_ST_FIRST: begin
               // Ready not looked at here: two states at the least
               state <= clbi_pkg::CLBI_ST_WAIT;
            end
            clbi_pkg::CLBI_ST_WAIT: begin
               // Pipelined address of a pending half is put out early
               if (!bus.next_addr_n && need_second && !pipe_q) begin
                  pipe_q <= 1'b1;
                  rem_be <= {be_q[3:2], 2'b11};
                  ads_q  <= 1'b1;
               end
               if (ack) begin
                  // An announced half goes straight to its wait state
                  if (need_second || pipe_q) begin
                     be_q   <= pipe_q ? rem_be : {be_q[3:2], 2'b11};
                     ads_q  <= !pipe_q;
                     pipe_q <= 1'b0;
                     state  <= pipe_q ? clbi_pkg::CLBI_ST_WAIT
                                      : clbi_pkg::CLBI_ST_FIRST;
                  end else if (req_valid && req_ready) begin
                     // Back to back: next address on the acknowledge edge
                     addr_q  <= req_addr;
                     be_q    <= req_be_n;
                     type_q  <= req_type;
                     wdata_q <= req_wdata;
                     ads_q   <= 1'b1;
                     state   <= clbi_pkg::CLBI_ST_FIRST;
                  end else begin
                     // Released enables mark the bus idle between cycles
                     be_q  <= `CLBI_BE_IDLE;
                     state <= clbi_pkg::CLBI_ST_IDLE;
                  end
               end
            end
            clbi_pkg::CLBI_ST_HELD: begin
               // Granted from idle only, so no cycle is ever cut short
               if (!bus.hold)
                  state <= clbi_pkg::CLBI_ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Read data capture
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         // A split read reports once, after its second half
         rsp_valid <= ack && !need_second && !pipe_q && !is_write;
         if (ack && !is_write) begin
            // Upper half on a 16-bit bus arrives on the low lanes
            if (!bus.half_width_bus_n && be_q[1:0] == 2'b11)
               rsp_rdata[31:16] <= bus.data_in[15:0];
            else
               rsp_rdata <= bus.data_in;
         end
      end
   end

   // ---------------------------------------------------------------
   // Enables on the pins
   // ---------------------------------------------------------------
   // An announced half shows its enables early; data steering keeps to
   // the enables of the cycle still in flight
   always_comb begin
      bus_be = be_q;
      if (pipe_q)
         bus_be = rem_be;
   end

   // ---------------------------------------------------------------
   // Pins
   // ---------------------------------------------------------------
   // Upper-half-only writes repeat onto the low lanes
   always_comb begin
      dup_data = wdata_q;
      if (be_q[1:0] == 2'b11)
         dup_data[15:0] = wdata_q[31:16];
   end

   assign bus.addr_status_n = !ads_q;
   assign bus.byte_lane_enables_n = bus_be;
   assign bus.word_address = addr_q[29:0];
   // Memory select high for memory cycles
   assign {bus.memory_io, bus.data_ctrl, bus.write_read} = type_q;
   assign bus.data_out = dup_data;
   // All 32 lines driven on writes, halt and shutdown alike
   assign bus.data_oe = is_write && (state != clbi_pkg::CLBI_ST_IDLE)
                        && (state != clbi_pkg::CLBI_ST_HELD);
   // Address and control float while the bus is released
   assign bus.bus_oe = (state != clbi_pkg::CLBI_ST_HELD);
   assign bus.hold_acknowledge = (state == clbi_pkg::CLBI_ST_HELD);
   assign bus.phase = phase_q;
endmodule : clbi_cpu_end

/* File: clbi_consts.svh */
// Constants for the local bus interface: widths, addresses, enables, timing
`ifndef CLBI_CONSTS_SVH
`define CLBI_CONSTS_SVH
`define CLBI_ADDR_W        30
`define CLBI_DATA_W        32
`define CLBI_LANES         4
`define CLBI_IO_ADDR_MAX   32'h0000ffff
`define CLBI_COP_ADDR_LO   32'h800000f8
`define CLBI_COP_ADDR_HI   32'h800000ff
`define CLBI_MIN_STATES    2
`define CLBI_BE_IDLE       4'hf
`define CLBI_HALT_BE_N     4'hb
`define CLBI_SHUT_BE_N     4'he
`endif

/* File: clbi_pkg.sv */
// Types used by the processor end and the bench of the local bus interface
package clbi_pkg;
   // Cycle definition {memory_io, data_ctrl, write_read}
   typedef enum logic [2:0] {
      CLBI_INTA      = 3'b000,
      CLBI_NEVER     = 3'b001,
      CLBI_IO_READ   = 3'b010,
      CLBI_IO_WRITE  = 3'b011,
      CLBI_CODE_READ = 3'b100,
      CLBI_HALT_SHUT = 3'b101,
      CLBI_MEM_READ  = 3'b110,
      CLBI_MEM_WRITE = 3'b111
   } clbi_cycle_t;
   typedef enum logic [1:0] {
      CLBI_ST_IDLE  = 2'b00,
      CLBI_ST_FIRST = 2'b01,
      CLBI_ST_WAIT  = 2'b10,
      CLBI_ST_HELD  = 2'b11
   } clbi_state_t;
endpackage : clbi_pkg

/* File: clbi_if.sv */
// Local bus wires joining the processor end and the system end
`timescale 1ns/10ps
interface clbi_if;
   logic [3:0]  byte_lane_enables_n;
   logic [29:0] word_address;
   logic        memory_io;
   logic        data_ctrl;
   logic        write_read;
   logic        addr_status_n;
   logic        bus_oe;
   logic [31:0] data_out;
   logic        data_oe;
   logic [31:0] data_in;
   logic        ready_n;
   logic        next_addr_n;
   logic        half_width_bus_n;
   logic        hold;
   logic        hold_acknowledge;
   logic        phase;

   modport cpu (
      output byte_lane_enables_n, word_address, memory_io, data_ctrl,
             write_read, addr_status_n, bus_oe, data_out, data_oe,
             hold_acknowledge, phase,
      input  data_in, ready_n, next_addr_n, half_width_bus_n, hold
   );
   modport sys (
      input  byte_lane_enables_n, word_address, memory_io, data_ctrl,
             write_read, addr_status_n, bus_oe, data_out, data_oe,
             hold_acknowledge, phase,
      output data_in, ready_n, next_addr_n, half_width_bus_n, hold
   );
endinterface : clbi_if

/* File: clbi_sys_end.sv */
// System end: acknowledges cycles, answers reads, steers sizing/pipelining
`timescale 1ns/10ps
`include "clbi_consts.svh"
module clbi_sys_end #(
   parameter int WAIT_STATES = 0
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   clbi_if.sys              bus,
   input  wire logic        cfg_half_width,
   input  wire logic        cfg_pipeline,
   input  wire logic        cfg_hold,
   input  wire logic [31:0] rd_data,
   output logic             cyc_seen,
   output logic [29:0]      cyc_addr,
   output logic [3:0]       cyc_be_n,
   output logic [2:0]       cyc_type,
   output logic [31:0]      cyc_wdata,
   output logic             cyc_done
);
   logic [7:0]  wait_cnt;
   logic        busy;
   logic [31:0] rd_q;
   logic        pend;
   logic [3:0]  cur_be_n;
   logic [3:0]  pend_be_n;
   logic        new_cyc;
   logic        ack_now;
   logic [7:0]  wait_need;

   assign new_cyc = !bus.addr_status_n;
   assign ack_now = busy && !bus.ready_n;
   // A pipelining system answers one state later, which leaves room
   // for the next address to be announced early
   assign wait_need = 8'(WAIT_STATES) + {7'h00, cfg_pipeline};

   // ---------------------------------------------------------------
   // Cycle capture and acknowledge
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         busy      <= 1'b0;
         pend      <= 1'b0;
         wait_cnt  <= 8'h00;
         cyc_seen  <= 1'b0;
         cyc_addr  <= '0;
         cyc_be_n  <= `CLBI_BE_IDLE;
         cyc_type  <= 3'h0;
         cur_be_n  <= `CLBI_BE_IDLE;
         pend_be_n <= `CLBI_BE_IDLE;
      end else begin
         cyc_seen <= new_cyc;
         if (new_cyc) begin
            cyc_addr <= bus.word_address;
            cyc_be_n <= bus.byte_lane_enables_n;
            cyc_type <= {bus.memory_io, bus.data_ctrl, bus.write_read};
         end
         if (!busy) begin
            if (new_cyc) begin
               busy     <= 1'b1;
               wait_cnt <= 8'h00;
               cur_be_n <= bus.byte_lane_enables_n;
            end
         end else if (ack_now) begin
            // A pipelined address takes over as soon as the last one ends
            if (new_cyc || pend) begin
               wait_cnt <= 8'h00;
               pend     <= 1'b0;
               cur_be_n <= new_cyc ? bus.byte_lane_enables_n : pend_be_n;
            end else begin
               busy <= 1'b0;
            end
         end else begin
            wait_cnt <= wait_cnt + 8'h01;
            if (new_cyc) begin
               pend      <= 1'b1;
               pend_be_n <= bus.byte_lane_enables_n;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cyc_wdata <= '0;
         cyc_done  <= 1'b0;
         rd_q      <= '0;
      end else begin
         cyc_done <= busy && !bus.ready_n;
         rd_q     <= rd_data;
         if (busy && !bus.ready_n && bus.data_oe)
            cyc_wdata <= bus.data_out;
      end
   end

   // Acknowledge only after the first state; data always fully driven
   assign bus.ready_n = !(busy && wait_cnt >= wait_need);
   // A 16-bit system hands the upper half over on the low lanes
   assign bus.data_in = (cfg_half_width && cur_be_n[1:0] == 2'b11)
                        ? {rd_q[31:16], rd_q[31:16]} : rd_q;
   assign bus.half_width_bus_n = !cfg_half_width;
   assign bus.next_addr_n = !cfg_pipeline;
   assign bus.hold = cfg_hold;
endmodule : clbi_sys_end

/* File: clbi_checker.sv */
// Concurrent checks on the local bus wires between the two ends
`timescale 1ns/10ps
module clbi_checker (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [3:0]  byte_lane_enables_n,
   input wire logic [29:0] word_address,
   input wire logic        memory_io,
   input wire logic        data_ctrl,
   input wire logic        write_read,
   input wire logic        addr_status_n,
   input wire logic        bus_oe,
   input wire logic [31:0] data_out,
   input wire logic        data_oe,
   input wire logic        half_width_bus_n,
   input wire logic        hold_acknowledge,
   input wire logic        phase
);
   // ----------------------------------------
   // Cycle starts
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence start_s; !addr_status_n; endsequence
   // Wide cycles are never pipelined, so their address must hold
   sequence wide_s; start_s ##0 half_width_bus_n; endsequence
   sequence split_s;
      start_s ##0 !half_width_bus_n && byte_lane_enables_n[1:0] != 2'b11
         && byte_lane_enables_n[3:2] != 2'b11;
   endsequence
   cycle_code_legal_a:
      assert property (start_s |-> {memory_io, data_ctrl, write_read} != 3'b001)
      else $error("illegal cycle code with address status");
   start_drives_bus_a:
      assert property (start_s |-> bus_oe) else $error("address not driven");
   enables_present_a:
      assert property (start_s |-> byte_lane_enables_n != 4'hf)
      else $error("cycle with no byte lane enabled");
   wide_addr_stable_a:
      assert property (wide_s |=> $stable({word_address, byte_lane_enables_n,
         memory_io, data_ctrl, write_read})) else $error("address moved");
   write_drives_data_a:
      assert property (start_s ##0 write_read |=> data_oe)
      else $error("write without data driven");
   upper_dup_a:
      assert property (wide_s ##0 write_read && data_ctrl &&
         byte_lane_enables_n[1:0] == 2'b11 |=>
         data_out[15:0] == data_out[31:16]) else $error("no duplication");
   split_second_a:
      assert property (split_s |-> ##[1:8]
         (!addr_status_n && byte_lane_enables_n[1:0] == 2'b11))
      else $error("second half cycle missing");
   release_floats_a:
      assert property (hold_acknowledge |-> !bus_oe && !data_oe)
      else $error("bus driven while released");
   phase_toggles_a:
      assert property (!reset |=> phase != $past(phase))
      else $error("phase did not toggle");
   reset_phase_a:
      assert property (disable iff (1'b0) reset |=> !phase)
      else $error("phase not aligned by reset");
   reset_idle_a:
      assert property (disable iff (1'b0) reset |=> addr_status_n &&
         !hold_acknowledge && !data_oe) else $error("bus busy in reset");
endmodule : clbi_checker

/* File: cpu_local_bus_interface_bench.sv */
// Self-checking bench: processor end and system end joined by one bus
`timescale 1ns/10ps
module cpu_local_bus_interface_bench;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_ready, rsp_valid, cyc_seen, cyc_done;
   logic [29:0] req_addr = 30'h0;
   logic [3:0]  req_be_n = 4'hf;
   clbi_pkg::clbi_cycle_t req_type = clbi_pkg::CLBI_MEM_READ;
   logic [31:0] req_wdata = 32'h0, rd_data = 32'h0;
   logic        cfg_half_width = 1'b0, cfg_pipeline = 1'b0, cfg_hold = 1'b0;
   logic [31:0] rsp_rdata, cyc_wdata, last_rd;
   logic [29:0] cyc_addr;
   logic [3:0]  cyc_be_n;
   logic [2:0]  cyc_type;
   int          mismatches = 0, compares = 0, n_seen, n_done;
   logic [29:0] q_a[$];
   logic [3:0]  q_b[$];
   logic [31:0] q_w[$];
   logic [2:0]  q_t[$];
   logic [3:0]  be_tab [10] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h9, 4'h3,
                                4'h8, 4'h1, 4'h0};
   logic [2:0]  t_tab [4] = '{3'b010, 3'b011, 3'b110, 3'b111};

   clbi_if bus_if ();
   clbi_cpu_end i_clbi_cpu_end (.core_clk(core_clk), .reset(reset),
      .bus(bus_if.cpu), .req_valid(req_valid), .req_ready(req_ready),
      .req_addr(req_addr), .req_be_n(req_be_n), .req_type(req_type),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   clbi_sys_end i_clbi_sys_end (.core_clk(core_clk), .reset(reset),
      .bus(bus_if.sys), .cfg_half_width(cfg_half_width),
      .cfg_pipeline(cfg_pipeline), .cfg_hold(cfg_hold), .rd_data(rd_data),
      .cyc_seen(cyc_seen), .cyc_addr(cyc_addr), .cyc_be_n(cyc_be_n),
      .cyc_type(cyc_type), .cyc_wdata(cyc_wdata), .cyc_done(cyc_done));
   clbi_checker u_check (.core_clk(core_clk), .reset(reset),
      .byte_lane_enables_n(bus_if.byte_lane_enables_n),
      .word_address(bus_if.word_address), .memory_io(bus_if.memory_io),
      .data_ctrl(bus_if.data_ctrl), .write_read(bus_if.write_read),
      .addr_status_n(bus_if.addr_status_n), .bus_oe(bus_if.bus_oe),
      .data_out(bus_if.data_out), .data_oe(bus_if.data_oe),
      .half_width_bus_n(bus_if.half_width_bus_n),
      .hold_acknowledge(bus_if.hold_acknowledge), .phase(bus_if.phase));

   always #20 core_clk = ~core_clk;

   // ----------------------------------------
   // Observed cycles
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (cyc_seen === 1'b1) begin
         q_a.push_back(cyc_addr);
         q_b.push_back(cyc_be_n);
         q_t.push_back(cyc_type);
         n_seen++;
      end
      if (cyc_done === 1'b1) begin
         q_w.push_back(cyc_wdata);
         n_done++;
      end
      if (rsp_valid === 1'b1) last_rd = rsp_rdata;
   end

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   function automatic logic [31:0] lanes(logic [3:0] b);
      lanes = {{8{~b[3]}}, {8{~b[2]}}, {8{~b[1]}}, {8{~b[0]}}};
   endfunction : lanes

   task automatic txn(logic [2:0] t, logic [29:0] a, logic [3:0] b, logic hw);
      int          k;
      int          n;
      logic [31:0] w, ex, m, m2;
      n = (hw && b[1:0] != 2'b11 && b[3:2] != 2'b11) ? 2 : 1;
      w = $urandom;
      q_a.delete();
      q_b.delete();
      q_t.delete();
      q_w.delete();
      n_seen = 0;
      n_done = 0;
      last_rd = 'x;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_type <= clbi_pkg::clbi_cycle_t'(t);
      req_addr <= a;
      req_be_n <= b;
      req_wdata <= w;
      rd_data <= $urandom;
      cfg_half_width <= hw;
      cfg_pipeline <= 1'($urandom);
      for (k = 0; k < 20; k++) begin
         @(posedge core_clk);
         if (req_ready === 1'b1) break;
      end
      req_valid <= 1'b0;
      for (k = 0; k < 40 && n_done < n; k++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      chk("cycles", n, n_seen);
      chk("addr", a, q_a[0]);
      chk("enables", b, q_b[0]);
      chk("type", t, q_t[0]);
      if (n == 2) chk("enables2", {b[3:2], 2'b11}, q_b[1]);
      ex = (b[1:0] == 2'b11) ? {w[31:16], w[31:16]} : w;
      m = (n == 2) ? lanes(b) & 32'h0000ffff : lanes(b) | (lanes(b) >> 16);
      m2 = lanes(b) >> 16;
      if (t[1:0] == 2'b11) chk("wdata", ex & m, q_w[0] & m);
      if (t[1:0] == 2'b11 && n == 2) chk("wdata2", (w >> 16) & m2, q_w[1] & m2);
      if (!t[0]) chk("rdata", rd_data & lanes(b), last_rd & lanes(b));
   endtask : txn

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #800000;
      mismatches++;
      tally_and_finish();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h229c522d));
      repeat (5) @(posedge core_clk);
      chk("ready_in_reset", 1'b0, req_ready);
      @(posedge core_clk);
      reset <= 1'b0;
      for (int t = 0; t < 8; t++) begin
         if (t == 5) txn(3'b101, 30'h0, `CLBI_HALT_BE_N, 1'b0);
         else if (t != 1) txn(3'(t), 30'($urandom), 4'h0, 1'b0);
      end
      txn(3'b011, 30'h2000003e, 4'h0, 1'b0);
      repeat (40) txn(t_tab[$urandom_range(3)], 30'($urandom),
                      be_tab[$urandom_range(9)], 1'($urandom));
      req_type <= clbi_pkg::CLBI_NEVER;
      req_valid <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("never_refused", 1'b0, req_ready);
      req_valid <= 1'b0;
      cfg_hold <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("hold_ack", 1'b1, bus_if.hold_acknowledge);
      chk("hold_float", 1'b0, bus_if.bus_oe);
      cfg_hold <= 1'b0;
      repeat (4) @(posedge core_clk);
      txn(3'b111, 30'($urandom), 4'h3, 1'b1);
      tally_and_finish();
   end
endmodule : cpu_local_bus_interface_bench
